/* ocg_map.svh */
`ifndef OCG_MAP_SVH
`define OCG_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define OCG_ADDR_OSC_CONTROL  8'h00
`define OCG_ADDR_CLK_STATUS   8'h04
`define OCG_ADDR_IRQ_STATUS   8'h08
`define OCG_ADDR_IRQ_MASK     8'h0C

// ----------------------------------------------------------------
// osc_control fields and reset values
// ----------------------------------------------------------------
`define OCG_BIT_STANDBY       7
`define OCG_BIT_FREQ_SEL      6
`define OCG_BIT_SUPPLY_SEL    5
`define OCG_BIT_DIV_HI        1
`define OCG_BIT_DIV_LO        0
`define OCG_RST_STANDBY       1'b0
`define OCG_RST_FREQ_SEL      1'b1
`define OCG_RST_SUPPLY_SEL    1'b0
`define OCG_RST_DIV_SEL       2'h2
`define OCG_RSVD_BITS         3'h0

// ----------------------------------------------------------------
// status and interrupt fields
// ----------------------------------------------------------------
`define OCG_BIT_SWITCH_STAT   0
`define OCG_IRQ_W             2
`define OCG_IRQ_TO_ONCHIP     0
`define OCG_IRQ_DIV_REFUSED   1

// ----------------------------------------------------------------
// divider terminal counts (ratio minus one)
// ----------------------------------------------------------------
`define OCG_DIV2_LAST         3'h1
`define OCG_DIV4_LAST         3'h3
`define OCG_DIV8_LAST         3'h7

// ----------------------------------------------------------------
// prescaler geometry
// ----------------------------------------------------------------
`define OCG_PRESC_S_W         13
`define OCG_PRESC_W_W         7
`define OCG_PRESC_W_LOW       2

`define OCG_RESP_OKAY         2'h0
`define OCG_RESP_SLVERR       2'h2

`endif

/* ocg_pkg.sv */
package ocg_pkg;

  typedef enum logic [1:0] {
    OCG_WR_IDLE = 2'h1,
    OCG_WR_RESP = 2'h2
  } ocg_wr_state_e;

  typedef enum logic [1:0] {
    OCG_RD_IDLE = 2'h1,
    OCG_RD_RESP = 2'h2
  } ocg_rd_state_e;

  typedef logic [1:0] ocg_div_sel_t;

endpackage

/* ocg_presc_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface ocg_presc_if #(
  parameter int WIDTH = 13
);
  logic             tick;
  logic [WIDTH-1:0] taps;

  modport src (output tick, input taps);
  modport presc (input tick, output taps);
endinterface

`default_nettype wire

/* ocg_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

// ripple-free binary prescaler; tap k pulses once per 2^(k+1) input ticks
module ocg_prescaler #(
  parameter int WIDTH = 13
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  ocg_presc_if.presc pif
);

  logic [WIDTH-1:0] count;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (pif.tick) begin
      count <= count + 1'b1;
    end
  end

  // tap k fires on the tick that wraps bits k..0
  genvar k;
  generate
    for (k = 0; k < WIDTH; k++) begin : g_tap
      assign pif.taps[k] = pif.tick & (&count[k:0]);
    end
  endgenerate

endmodule

`default_nettype wire

/* ocg_clock_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ocg_map.svh"

module ocg_clock_control (
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [7:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic [1:0]                          s_axi_bresp,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [7:0]                     s_axi_araddr,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  input  wire logic                           ext_clock_active,
  input  wire logic                           ext_osc_in,
  input  wire logic                           sub_clk_in,
  output logic                                osc_system_clock,
  output logic                                fast_timer_clock,
  output logic [`OCG_PRESC_S_W-1:0]           presc_s_ticks,
  output logic [`OCG_PRESC_W_W-`OCG_PRESC_W_LOW-1:0] presc_w_ticks,
  output logic                                osc_standby,
  output logic                                osc_freq_select,
  output logic                                osc_supply_select,
  output logic                                sys_clk_from_ext,
  output logic                                irq
);
  import ocg_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ocg_wr_state_e          wr_state;
  ocg_rd_state_e          rd_state;
  logic                   aw_got;
  logic                   w_got;
  logic [7:0]             aw_addr_q;
  logic [31:0]            w_data_q;
  logic [3:0]             w_strb_q;
  logic                   wr_fire;
  logic                   standby_q;
  logic                   freq_sel_q;
  logic                   supply_sel_q;
  ocg_div_sel_t           div_sel;
  logic [`OCG_IRQ_W-1:0]  irq_status;
  logic [`OCG_IRQ_W-1:0]  irq_mask;
  logic [`OCG_IRQ_W-1:0]  irq_set;
  logic [`OCG_IRQ_W-1:0]  irq_clr;
  logic [2:0]             pin_s1;
  logic [2:0]             pin_s2;
  logic                   ext_active_prev;
  logic                   ext_osc_prev;
  logic                   sub_clk_prev;
  logic                   switch_status;
  logic                   to_onchip_evt;
  logic                   div_refused_evt;
  logic [2:0]             div_count;
  logic [2:0]             div_last;
  logic                   rc_tick;
  logic                   ext_tick;
  logic                   next_sys_tick;
  logic                   sub_tick;

  ocg_presc_if #(.WIDTH(`OCG_PRESC_S_W)) presc_s_if ();
  ocg_presc_if #(.WIDTH(`OCG_PRESC_W_W)) presc_w_if ();

  // ----------------------------------------------------------------
  // address decode, shared by the write and read paths
  // ----------------------------------------------------------------
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `OCG_ADDR_OSC_CONTROL) || (a == `OCG_ADDR_CLK_STATUS) ||
                  (a == `OCG_ADDR_IRQ_STATUS) || (a == `OCG_ADDR_IRQ_MASK);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = 32'h0000_0000;
    case (a)
      `OCG_ADDR_OSC_CONTROL: read_word = {24'h00_0000, standby_q, freq_sel_q, supply_sel_q,
                                          `OCG_RSVD_BITS, div_sel};
      `OCG_ADDR_CLK_STATUS:  read_word = {31'h0000_0000, switch_status};
      `OCG_ADDR_IRQ_STATUS:  read_word = {30'h0000_0000, irq_status};
      `OCG_ADDR_IRQ_MASK:    read_word = {30'h0000_0000, irq_mask};
      default:               read_word = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // bit 0 external clock active, bit 1 external oscillator, bit 2 subclock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {sub_clk_in, ext_osc_in, ext_clock_active};
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ext_active_prev <= 1'b0;
      ext_osc_prev    <= 1'b0;
      sub_clk_prev    <= 1'b0;
    end else begin
      ext_active_prev <= pin_s2[0];
      ext_osc_prev    <= pin_s2[1];
      sub_clk_prev    <= pin_s2[2];
    end
  end

  assign switch_status = pin_s2[0];
  assign ext_tick      = pin_s2[1] & ~ext_osc_prev;
  assign sub_tick      = pin_s2[2] & ~sub_clk_prev;
  // source falls from external back to on-chip
  assign to_onchip_evt = ext_active_prev & ~pin_s2[0];

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data may arrive in either order; both are held until
  // the write is done so the master can release each independently
  assign wr_fire = (wr_state == OCG_WR_IDLE) && aw_got && w_got;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_got    <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got    <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_got    <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      w_got    <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got    <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_got    <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_state     <= OCG_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OCG_RESP_OKAY;
    end else begin
      case (wr_state)
        OCG_WR_IDLE: begin
          if (wr_fire) begin
            wr_state     <= OCG_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(aw_addr_q) ? `OCG_RESP_OKAY : `OCG_RESP_SLVERR;
          end
        end
        OCG_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state     <= OCG_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state     <= OCG_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_state      <= OCG_RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OCG_RESP_OKAY;
    end else begin
      case (rd_state)
        OCG_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state      <= OCG_RD_RESP;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= read_word(s_axi_araddr);
            s_axi_rresp   <= addr_mapped(s_axi_araddr) ? `OCG_RESP_OKAY : `OCG_RESP_SLVERR;
          end
        end
        OCG_RD_RESP: begin
          if (s_axi_rready) begin
            rd_state      <= OCG_RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
          end
        end
        default: begin
          rd_state      <= OCG_RD_IDLE;
          s_axi_arready <= 1'b1;
          s_axi_rvalid  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // oscillator control register
  // ----------------------------------------------------------------
  // reserved bits 4..2 have no storage, so writes there vanish
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      standby_q    <= `OCG_RST_STANDBY;
      freq_sel_q   <= `OCG_RST_FREQ_SEL;
      supply_sel_q <= `OCG_RST_SUPPLY_SEL;
    end else if (wr_fire && aw_addr_q == `OCG_ADDR_OSC_CONTROL && w_strb_q[0]) begin
      standby_q    <= w_data_q[`OCG_BIT_STANDBY];
      freq_sel_q   <= w_data_q[`OCG_BIT_FREQ_SEL];
      supply_sel_q <= w_data_q[`OCG_BIT_SUPPLY_SEL];
    end
  end

  // divider field is frozen while the external clock is in charge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_sel <= `OCG_RST_DIV_SEL;
    end else if (wr_fire && aw_addr_q == `OCG_ADDR_OSC_CONTROL && w_strb_q[0]
                 && !switch_status) begin
      div_sel <= w_data_q[`OCG_BIT_DIV_HI:`OCG_BIT_DIV_LO];
    end
  end

  assign div_refused_evt = wr_fire && aw_addr_q == `OCG_ADDR_OSC_CONTROL
                           && w_strb_q[0] && switch_status;

  // ----------------------------------------------------------------
  // on-chip divider and clock select
  // ----------------------------------------------------------------
  always_comb begin
    case (div_sel)
      2'h2:    div_last = `OCG_DIV4_LAST;
      2'h3:    div_last = `OCG_DIV8_LAST;
      default: div_last = `OCG_DIV2_LAST;
    endcase
  end

  // compare against the live field so a rewrite acts at once; a count
  // already past the new limit wraps instead of running to 7
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_count <= 3'h0;
    end else if (standby_q) begin
      div_count <= 3'h0;
    end else if (div_count >= div_last) begin
      div_count <= 3'h0;
    end else begin
      div_count <= div_count + 3'h1;
    end
  end

  assign rc_tick       = !standby_q && (div_count == div_last);
  assign next_sys_tick = switch_status ? ext_tick : rc_tick;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_system_clock <= 1'b0;
      sys_clk_from_ext <= 1'b0;
    end else begin
      osc_system_clock <= next_sys_tick;
      sys_clk_from_ext <= switch_status;
    end
  end

  // undivided oscillator rate, stopped only by standby
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fast_timer_clock <= 1'b0;
    end else begin
      fast_timer_clock <= !standby_q;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_standby       <= `OCG_RST_STANDBY;
      osc_freq_select   <= `OCG_RST_FREQ_SEL;
      osc_supply_select <= `OCG_RST_SUPPLY_SEL;
    end else begin
      osc_standby       <= standby_q;
      osc_freq_select   <= freq_sel_q;
      osc_supply_select <= supply_sel_q;
    end
  end

  // ----------------------------------------------------------------
  // peripheral prescalers
  // ----------------------------------------------------------------
  assign presc_s_if.tick = osc_system_clock;
  assign presc_w_if.tick = sub_tick;

  ocg_prescaler #(.WIDTH(`OCG_PRESC_S_W)) u_presc_s (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pif      (presc_s_if.presc)
  );

  ocg_prescaler #(.WIDTH(`OCG_PRESC_W_W)) u_presc_w (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pif      (presc_w_if.presc)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      presc_s_ticks <= '0;
      presc_w_ticks <= '0;
    end else begin
      presc_s_ticks <= presc_s_if.taps;
      presc_w_ticks <= presc_w_if.taps[`OCG_PRESC_W_W-1:`OCG_PRESC_W_LOW];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  assign irq_set = {div_refused_evt, to_onchip_evt};
  assign irq_clr = (wr_fire && aw_addr_q == `OCG_ADDR_IRQ_STATUS && w_strb_q[0])
                   ? w_data_q[`OCG_IRQ_W-1:0] : '0;

  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= '0;
    end else if (wr_fire && aw_addr_q == `OCG_ADDR_IRQ_MASK && w_strb_q[0]) begin
      irq_mask <= w_data_q[`OCG_IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

`default_nettype wire

/* ocg_clk_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// far side: external crystal with its presence pin, and the subclock source
module ocg_clk_partner #(
  parameter int EXT_HALF = 3,
  parameter int SUB_HALF = 2
) (
  input  wire logic core_clk,
  input  wire logic ext_on,
  output logic      ext_clock_active,
  output logic      ext_osc_in,
  output logic      sub_clk_in
);
  int ext_cnt;
  int sub_cnt;

  initial begin
    ext_clock_active = 1'b0;
    ext_osc_in = 1'b0;
    sub_clk_in = 1'b0;
    ext_cnt = 0;
    sub_cnt = 0;
  end

  // crystal stops low while the external source is off
  always @(posedge core_clk) begin
    ext_clock_active <= ext_on;
    if (!ext_on) begin
      ext_cnt <= 0;
      ext_osc_in <= 1'b0;
    end else if (ext_cnt == EXT_HALF - 1) begin
      ext_cnt <= 0;
      ext_osc_in <= ~ext_osc_in;
    end else begin
      ext_cnt <= ext_cnt + 1;
    end
  end

  always @(posedge core_clk) begin
    if (sub_cnt == SUB_HALF - 1) begin
      sub_cnt <= 0;
      sub_clk_in <= ~sub_clk_in;
    end else begin
      sub_cnt <= sub_cnt + 1;
    end
  end
endmodule

`default_nettype wire

/* ocg_clock_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ocg_map.svh"

module ocg_clock_control_props (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        ext_osc_in,
  input wire logic        osc_system_clock,
  input wire logic        fast_timer_clock,
  input wire logic [12:0] presc_s_ticks,
  input wire logic [4:0]  presc_w_ticks,
  input wire logic        osc_standby,
  input wire logic        sys_clk_from_ext
);
  logic [7:0] rd_addr;
  logic [4:0] quiet_cnt;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_addr <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end

  // on-chip gap counter; standby and external may be silent
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      quiet_cnt <= 5'h00;
    end else if (osc_system_clock || osc_standby || sys_clk_from_ext) begin
      quiet_cnt <= 5'h00;
    end else if (quiet_cnt != 5'h1F) begin
      quiet_cnt <= quiet_cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  chk_rsvd_read: assert property (s_axi_rvalid && rd_addr == `OCG_ADDR_OSC_CONTROL
    |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[4:2] == 3'h0) else $error("reserved bits read nonzero");
  chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == `OCG_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  chk_tick_single: assert property ((!sys_clk_from_ext)[*4] ##0 osc_system_clock |=> !osc_system_clock)
    else $error("system tick longer than one cycle");
  chk_onchip_runs: assert property (quiet_cnt <= 5'h0C)
    else $error("on-chip system tick missing");
  chk_fast_on: assert property ($past(nrst) && !osc_standby && !$past(osc_standby) |-> fast_timer_clock)
    else $error("fast timer clock missing");
  chk_standby_off: assert property (osc_standby && $past(osc_standby) |-> !fast_timer_clock)
    else $error("fast timer clock runs in standby");
  chk_standby_quiet: assert property ((osc_standby && !sys_clk_from_ext)[*3] |-> !osc_system_clock)
    else $error("system tick in standby");
  chk_ext_quiet: assert property ((sys_clk_from_ext && !ext_osc_in)[*6] |-> !osc_system_clock)
    else $error("system tick without external edge");
  chk_presc_cause: assert property (presc_s_ticks != 13'h0 |-> $past(osc_system_clock))
    else $error("prescaler tick without system tick");
  chk_sub_pulse: assert property (presc_w_ticks[0] |=> !presc_w_ticks[0])
    else $error("subclock tap longer than one cycle");

  cov_ext_back: cover property ($fell(sys_clk_from_ext));
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == `OCG_RESP_SLVERR);
  cov_top_tap: cover property (presc_s_ticks[12]);
endmodule

bind ocg_clock_control ocg_clock_control_props u_props (
  .core_clk(core_clk), .nrst(nrst), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .ext_osc_in(ext_osc_in), .osc_system_clock(osc_system_clock),
  .fast_timer_clock(fast_timer_clock), .presc_s_ticks(presc_s_ticks), .presc_w_ticks(presc_w_ticks),
  .osc_standby(osc_standby), .sys_clk_from_ext(sys_clk_from_ext)
);

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ocg_map.svh"

module testbench;
  logic        core_clk, nrst, ext_on, ext_clock_active, ext_osc_in, sub_clk_in;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        osc_system_clock, fast_timer_clock, osc_standby, osc_freq_select;
  logic        osc_supply_select, sys_clk_from_ext;
  logic [12:0] presc_s_ticks;
  logic [4:0]  presc_w_ticks;
  logic [18:0] watch;
  logic [31:0] per [4] = '{32'h2, 32'h2, 32'h4, 32'h8};
  int          num_errors, n_checks, cyc, p;

  assign watch = {presc_w_ticks, presc_s_ticks, osc_system_clock};

  ocg_clk_partner far (.core_clk, .ext_on, .ext_clock_active, .ext_osc_in, .sub_clk_in);
  ocg_clock_control dut (
    .core_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .ext_clock_active, .ext_osc_in, .sub_clk_in, .osc_system_clock, .fast_timer_clock,
    .presc_s_ticks, .presc_w_ticks, .osc_standby, .osc_freq_select, .osc_supply_select,
    .sys_clk_from_ext, .irq
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string nm);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(nm, s_axi_rdata, ed);
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // cycles between two pulses of one watched tick
  task automatic measure(input int idx, output int n);
    n = 0;
    do @(posedge core_clk); while (watch[idx] !== 1'b1);
    do begin
      @(posedge core_clk);
      n++;
    end while (watch[idx] !== 1'b1);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    {nrst, ext_on, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check("osc_freq_select", osc_freq_select, 1'h1);
    check("osc_standby", osc_standby, 1'h0);
    check("osc_supply_select", osc_supply_select, 1'h0);
    rd(`OCG_ADDR_OSC_CONTROL, 32'h42, `OCG_RESP_OKAY, "osc_control");
    measure(0, p);
    check("sys_period", p, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr(`OCG_ADDR_OSC_CONTROL, {24'h0, 6'h10, i[1:0]}, `OCG_RESP_OKAY);
      measure(0, p);
      check("sys_period", p, per[i]);
      check("fast_timer_clock", fast_timer_clock, 1'h1);
    end
    wr(`OCG_ADDR_OSC_CONTROL, 32'hFF, `OCG_RESP_OKAY);
    rd(`OCG_ADDR_OSC_CONTROL, 32'hE3, `OCG_RESP_OKAY, "osc_control");
    check("osc_standby", osc_standby, 1'h1);
    check("fast_timer_clock", fast_timer_clock, 1'h0);
    wr(`OCG_ADDR_OSC_CONTROL, 32'h40, `OCG_RESP_OKAY);
    measure(1, p);
    check("presc_s_tap0", p, 32'h4);
    measure(13, p);
    check("presc_s_tap12", p, 32'h4000);
    measure(14, p);
    check("presc_w_tap0", p, 32'h20);
    measure(18, p);
    check("presc_w_tap4", p, 32'h200);
    rd(8'h10, 32'h0, `OCG_RESP_SLVERR, "unmapped");
    wr(8'h10, 32'h1, `OCG_RESP_SLVERR);
    wr(`OCG_ADDR_IRQ_MASK, 32'h3, `OCG_RESP_OKAY);
    rd(`OCG_ADDR_IRQ_MASK, 32'h3, `OCG_RESP_OKAY, "irq_mask");
    ext_on <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(`OCG_ADDR_CLK_STATUS, 32'h1, `OCG_RESP_OKAY, "clock_ctrl_status");
    measure(0, p);
    check("ext_period", p, 32'h6);
    // divider write refused, other bits land
    wr(`OCG_ADDR_OSC_CONTROL, 32'h23, `OCG_RESP_OKAY);
    rd(`OCG_ADDR_OSC_CONTROL, 32'h20, `OCG_RESP_OKAY, "osc_control");
    check("freq_supply", {osc_freq_select, osc_supply_select}, 32'h1);
    check("irq", irq, 1'h1);
    rd(`OCG_ADDR_IRQ_STATUS, 32'h2, `OCG_RESP_OKAY, "irq_status");
    wr(`OCG_ADDR_IRQ_STATUS, 32'h2, `OCG_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    check("irq", irq, 1'h0);
    ext_on <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("irq", irq, 1'h1);
    rd(`OCG_ADDR_IRQ_STATUS, 32'h1, `OCG_RESP_OKAY, "irq_status");
    rd(`OCG_ADDR_CLK_STATUS, 32'h0, `OCG_RESP_OKAY, "clock_ctrl_status");
    wr(`OCG_ADDR_OSC_CONTROL, 32'h23, `OCG_RESP_OKAY);
    rd(`OCG_ADDR_OSC_CONTROL, 32'h23, `OCG_RESP_OKAY, "osc_control");
    wr(`OCG_ADDR_IRQ_STATUS, 32'h1, `OCG_RESP_OKAY);
    wr(`OCG_ADDR_IRQ_MASK, 32'h0, `OCG_RESP_OKAY);
    ext_on <= 1'b1;
    repeat (10) @(posedge core_clk);
    ext_on <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("irq", irq, 1'h0);
    rd(`OCG_ADDR_IRQ_STATUS, 32'h1, `OCG_RESP_OKAY, "irq_status");
    close_out();
  end
endmodule

`default_nettype wire
